// file: logic/apa_pin_out.sv
// Purpose: Output pins of a primary-rate frame aligner.
// Assumes: Pin clocks are sampled by clk; framer logic shares clk.
// Notes: Registers are reached over a zero-wait APB slave.
`timescale 1ns/100ps
`include "apa_cfg.svh"

// How it works
// - Test outputs carry the coded transmit stream, unaffected by AIS.
// - Test code follows code select alone; sense bit, reset high.
// - Highway runs at 4096 or 2048 kbit/s per rate bit.
// - Highway data changes on system clock falling edges.
// - Slot 0 starts offset edges after the edge following sync.
// - In 24-channel mode slot mapping follows the translation bit.
// - 30-channel doubleframe parity makes the ones count even.
// - Parity shown the doubleframe after next, changing four clocks before its start.
// - Freeze goes active on framing error, sync loss or slip.
// - Freeze clears after one error-free superframe.
// - Disable bit inhibits freeze; simulation steps 2 and 6 force it.
// - Interrupt select turns the shared pin into the alarm interrupt.
// - Only alarm sources enabled in the mask raise the interrupt.
// - Writing one to the acknowledge bit removes the interrupt.
// - Channel parity, even or odd per type bit, stands with each slot.
// - Frame pulse is suppressed during sync loss, not by simulation.
// - Frame pulse comes from the route, 8 kHz, 480 or 640 ns wide.
// - 30-channel optical NRZ, sense bit, changes on route clock rise.
// - 24-channel multiframe begin pulses at every superframe start.
// - Extended superframe adds a pulse at frame 12.
// - F72 pulses every 12 frames; a flag marks the data link start.
// - Pulses last two frames; an acknowledge write ends one early.
module apa_pin_out (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sys_clock,
  input  wire logic                 system_sync_pulse_n,
  input  wire logic                 tx_route_clock,
  input  wire apa_pkg::apa_rx_evt_t rx_evt,
  input  wire apa_pkg::apa_tx_evt_t tx_evt,
  input  wire logic [7:0]           alarm_src,
  input  wire logic [3:0]           alarm_sim_step,
  output logic      [4:0]           store_rd_idx,
  input  wire logic [7:0]           store_rd_data,
  output logic                      rx_highway_data,
  output logic                      rx_channel_parity,
  output logic                      rx_frame_pulse_n,
  output logic                      shared_status_out,
  output logic                      test_out_pos,
  output logic                      test_out_neg,
  output logic                      optical_nrz_out,
  output logic                      tx_multiframe_begin,
  output logic                      datalink_start_flag
);
  import apa_pkg::*;

  typedef struct packed {
    logic [2:0]  s_sclk;
    logic [2:0]  s_sync;
    logic [2:0]  s_xr;
    logic        l_sclk;
    logic        l_sync;
    logic        l_xr;
    apa_ctrl_t   ctrl;
    logic [5:0]  tro;
    logic [2:0]  rco;
    logic [7:0]  mask;
    apa_hw_t     hw;
    logic        armed;
    logic [10:0] off_cnt;
    logic [1:0]  clk_cnt;
    logic [2:0]  bit_cnt;
    logic [5:0]  slot;
    logic        frame_odd;
    logic [7:0]  shreg;
    logic [4:0]  rd_idx;
    logic        rx_data;
    logic        ch_par;
    logic        df_acc;
    logic        df_pend;
    logic        dfp;
    logic        freeze;
    logic        sf_err;
    logic        irq;
    logic [4:0]  fp_cnt;
    logic        fp_n;
    logic        shared;
    logic        test_pos;
    logic        test_neg;
    logic        ami_last;
    logic        opt;
    logic        mfb;
    logic [1:0]  mf_left;
    logic        dl_flag;
    logic [31:0] prdata;
  } apa_state_t;

  apa_state_t st_r;
  apa_state_t st_nxt;

  // Maps a highway slot to a route channel; bit 5 flags a live slot.
  function automatic logic [5:0] slot_map(input logic [5:0] slot,
                                          input logic       pcm24,
                                          input logic       ctm);
    logic [5:0] res;
    res = 6'h00;
    if (slot[5]) begin
      res = 6'h00;
    end else if (!pcm24) begin
      res = {1'b1, slot[4:0]};
    end else if (ctm) begin
      if (slot != 6'h00 && slot <= 6'h18) begin
        res = {1'b1, 5'(slot - 6'h01)};
      end
    end else if (slot[1:0] != 2'b00) begin
      res = {1'b1, 5'(slot - {2'b00, slot[5:2]} - 6'h01)};
    end
    return res;
  endfunction

  // Falls left until the next slot boundary edge.
  function automatic logic [5:0] falls_left(input logic [2:0] bit_cnt,
                                            input logic [1:0] clk_cnt,
                                            input logic [2:0] cpb);
    logic [5:0] prod;
    prod = 6'(3'h7 - bit_cnt) * 6'(cpb);
    return 6'(prod + 6'(cpb - 3'h1) - 6'(clk_cnt));
  endfunction

  always_comb begin
    logic        sclk_fall;
    logic        sync_act;
    logic        xr_rise;
    logic [2:0]  cpb;
    logic [10:0] offs;
    logic        start;
    logic        next_slot;
    logic [5:0]  last_slot;
    logic [5:0]  map;
    logic [7:0]  byte_in;
    logic        mf_hit;
    logic        sim_frz;
    logic        wr;
    logic        rd;
    sclk_fall = 1'b0;
    sync_act = 1'b0;
    xr_rise = 1'b0;
    start = 1'b0;
    next_slot = 1'b0;
    map = 6'h00;
    byte_in = 8'h00;
    mf_hit = 1'b0;
    st_nxt = st_r;
    wr = psel & penable & pwrite;
    rd = psel & ~penable & ~pwrite;

    // Pin inputs take effect once the second and third stages agree.
    st_nxt.s_sclk = {st_r.s_sclk[1:0], sys_clock};
    st_nxt.s_sync = {st_r.s_sync[1:0], system_sync_pulse_n};
    st_nxt.s_xr = {st_r.s_xr[1:0], tx_route_clock};
    if (st_r.s_sclk[2] == st_r.s_sclk[1]) begin
      st_nxt.l_sclk = st_r.s_sclk[2];
      sclk_fall = st_r.l_sclk & ~st_r.s_sclk[2];
    end
    if (st_r.s_sync[2] == st_r.s_sync[1]) begin
      st_nxt.l_sync = st_r.s_sync[2];
      sync_act = st_r.l_sync & ~st_r.s_sync[2];
    end
    if (st_r.s_xr[2] == st_r.s_xr[1]) begin
      st_nxt.l_xr = st_r.s_xr[2];
      xr_rise = ~st_r.l_xr & st_r.s_xr[2];
    end

    case ({st_r.ctrl.hw_rate, st_r.ctrl.sclk_rate})
      2'b00:   cpb = 3'h2;
      2'b01:   cpb = 3'h4;
      2'b10:   cpb = 3'h1;
      default: cpb = 3'h2;
    endcase
    last_slot = st_r.ctrl.hw_rate ? `APA_SLOTS_4M : `APA_SLOTS_2M;
    offs = 11'({st_r.tro, 3'b000}) * 11'(cpb) + 11'(st_r.rco);

    if (sync_act) begin
      st_nxt.armed = 1'b1;
      st_nxt.rd_idx = 5'h00;
    end
    case (st_r.hw)
      HW_IDLE, HW_RUN: begin
        if (st_r.armed & sclk_fall) begin
          st_nxt.armed = 1'b0;
          st_nxt.off_cnt = offs;
          st_nxt.hw = HW_OFFS;
          start = (offs == 11'h000);
        end else if (st_r.hw == HW_RUN && sclk_fall) begin
          if (st_r.clk_cnt != 2'(cpb - 3'h1)) begin
            st_nxt.clk_cnt = 2'(st_r.clk_cnt + 2'h1);
          end else begin
            st_nxt.clk_cnt = 2'h0;
            st_nxt.bit_cnt = 3'(st_r.bit_cnt + 3'h1);
            next_slot = (st_r.bit_cnt == 3'h7);
          end
        end
      end
      HW_OFFS: begin
        if (sclk_fall) begin
          st_nxt.off_cnt = 11'(st_r.off_cnt - 11'h001);
          start = (st_r.off_cnt == 11'h001);
        end
      end
      default: begin
        st_nxt.hw = HW_IDLE;
      end
    endcase

    if (start) begin
      st_nxt.hw = HW_RUN;
      st_nxt.slot = 6'h00;
      st_nxt.frame_odd = 1'b0;
      st_nxt.df_acc = 1'b0;
      st_nxt.clk_cnt = 2'h0;
      st_nxt.bit_cnt = 3'h0;
      next_slot = 1'b1;
    end else if (next_slot) begin
      st_nxt.slot = (st_r.slot == last_slot) ? 6'h00
                  : 6'(st_r.slot + 6'h01);
      if (st_r.slot == last_slot) begin
        st_nxt.frame_odd = ~st_r.frame_odd;
      end
    end
    if (next_slot) begin
      map = slot_map(st_nxt.slot, st_r.ctrl.pcm24, st_r.ctrl.ctm);
      byte_in = map[5] ? store_rd_data : `APA_IDLE_BYTE;
      st_nxt.shreg = byte_in;
      st_nxt.ch_par = ^byte_in ^ st_r.ctrl.parity_type;
      map = slot_map((st_nxt.slot == last_slot) ? 6'h00
                     : 6'(st_nxt.slot + 6'h01),
                     st_r.ctrl.pcm24, st_r.ctrl.ctm);
      st_nxt.rd_idx = map[4:0];
    end else if (st_r.hw == HW_RUN && sclk_fall
                 && st_r.clk_cnt == 2'(cpb - 3'h1)) begin
      st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
    end
    if (st_nxt.hw == HW_RUN && (next_slot || st_nxt.shreg != st_r.shreg))
    begin
      st_nxt.rx_data = st_nxt.shreg[7];
      if (start) begin
        st_nxt.df_acc = st_nxt.shreg[7];
      end else if (next_slot && st_nxt.slot == 6'h00 && !st_nxt.frame_odd)
      begin
        st_nxt.df_pend = st_r.df_acc;
        st_nxt.df_acc = st_nxt.shreg[7];
      end else begin
        st_nxt.df_acc = st_r.df_acc ^ st_nxt.shreg[7];
      end
    end
    if (st_r.hw == HW_RUN && sclk_fall && st_r.frame_odd
        && st_r.slot == last_slot
        && falls_left(st_r.bit_cnt, st_r.clk_cnt, cpb) == `APA_DF_LEAD)
    begin
      st_nxt.dfp = st_r.df_pend;
    end

    if (rx_evt.superframe_start) begin
      if (!st_r.sf_err && !rx_evt.sync_lost) begin
        st_nxt.freeze = 1'b0;
      end
      st_nxt.sf_err = 1'b0;
    end
    if (rx_evt.framing_err | rx_evt.slip | rx_evt.sync_lost) begin
      st_nxt.freeze = 1'b1;
      st_nxt.sf_err = 1'b1;
    end

    if (wr && paddr == `APA_OFF_ACK && pwdata[`APA_ACK_ALARM]) begin
      st_nxt.irq = 1'b0;
    end
    if (|(alarm_src & st_r.mask)) begin
      st_nxt.irq = 1'b1;
    end

    sim_frz = (alarm_sim_step == `APA_SIM_STEP_A)
            | (alarm_sim_step == `APA_SIM_STEP_B);
    if (st_r.ctrl.irq_select) begin
      st_nxt.shared = st_nxt.irq;
    end else if (st_r.ctrl.pcm24) begin
      st_nxt.shared = ~st_r.ctrl.freeze_disable
                    & (st_nxt.freeze | sim_frz);
    end else begin
      st_nxt.shared = st_nxt.dfp;
    end

    if (st_r.fp_cnt != 5'h00) begin
      st_nxt.fp_cnt = 5'(st_r.fp_cnt - 5'h01);
      st_nxt.fp_n = (st_r.fp_cnt == 5'h01);
    end
    if (rx_evt.frame_start) begin
      st_nxt.fp_cnt = st_r.ctrl.pcm24 ? 5'(`APA_FP24_CYC)
                                      : 5'(`APA_FP30_CYC);
      st_nxt.fp_n = 1'b0;
    end
    if (rx_evt.sync_lost) begin
      st_nxt.fp_n = 1'b1;
      st_nxt.fp_cnt = 5'h00;
    end

    if (xr_rise) begin
      st_nxt.opt = ~st_r.ctrl.pcm24
                 & (tx_evt.data_bit ^ st_r.ctrl.optical_sense);
      if (st_r.ctrl.code_sel) begin
        st_nxt.test_pos = tx_evt.coded_pos ~^ st_r.ctrl.test_sense;
        st_nxt.test_neg = tx_evt.coded_neg ~^ st_r.ctrl.test_sense;
      end else begin
        st_nxt.test_pos = (tx_evt.data_bit & ~st_r.ami_last)
                        ~^ st_r.ctrl.test_sense;
        st_nxt.test_neg = (tx_evt.data_bit & st_r.ami_last)
                        ~^ st_r.ctrl.test_sense;
        st_nxt.ami_last = st_r.ami_last ^ tx_evt.data_bit;
      end
    end

    if (tx_evt.frame_start && st_r.mfb) begin
      st_nxt.mf_left = 2'(st_r.mf_left - 2'h1);
      st_nxt.mfb = (st_r.mf_left != 2'h1);
    end
    if (wr && paddr == `APA_OFF_ACK && pwdata[`APA_ACK_MF]) begin
      st_nxt.mfb = 1'b0;
    end
    if (wr && paddr == `APA_OFF_ACK && pwdata[`APA_ACK_DL]) begin
      st_nxt.dl_flag = 1'b0;
    end
    case (st_r.ctrl.mf_format)
      2'h2:    mf_hit = tx_evt.frame_num == 7'h00
                      || tx_evt.frame_num == `APA_ESF_DL_FRM;
      2'h3:    mf_hit = (tx_evt.frame_num % `APA_F72_STEP) == 7'h00;
      default: mf_hit = tx_evt.frame_num == 7'h00;
    endcase
    if (tx_evt.frame_start && mf_hit && st_r.ctrl.pcm24) begin
      st_nxt.mfb = 1'b1;
      st_nxt.mf_left = `APA_MF_LEN;
      if (st_r.ctrl.mf_format == 2'h3 && tx_evt.frame_num == 7'h00) begin
        st_nxt.dl_flag = 1'b1;
      end
    end

    // Registers take writes at the access edge; reads are set up early.
    if (wr && paddr == `APA_OFF_CTRL) begin
      st_nxt.ctrl = apa_ctrl_t'(pwdata[`APA_CTRL_W-1:0]);
    end
    if (wr && paddr == `APA_OFF_OFFS) begin
      st_nxt.rco = pwdata[2:0];
      st_nxt.tro = pwdata[`APA_OFFS_TRO_LSB+5:`APA_OFFS_TRO_LSB];
    end
    if (wr && paddr == `APA_OFF_MASK) begin
      st_nxt.mask = pwdata[7:0];
    end
    if (rd) begin
      case (paddr)
        `APA_OFF_CTRL: st_nxt.prdata = {20'h0_0000, st_r.ctrl};
        `APA_OFF_OFFS: st_nxt.prdata = {18'h0_0000, st_r.tro,
                                        5'h00, st_r.rco};
        `APA_OFF_MASK: st_nxt.prdata = {24'h00_0000, st_r.mask};
        `APA_OFF_STAT: st_nxt.prdata = {24'h00_0000, st_r.hw == HW_RUN,
                                        st_r.dl_flag, st_r.mfb,
                                        st_r.shared, st_r.dfp,
                                        st_r.freeze, st_r.fp_n, st_r.irq};
        default:       st_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.s_sync <= 3'h7;
      st_r.l_sync <= 1'b1;
      st_r.ctrl <= apa_ctrl_t'(`APA_CTRL_RST);
      st_r.hw <= HW_IDLE;
      st_r.fp_n <= 1'b1;
      st_r.test_pos <= 1'b1;
      st_r.test_neg <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable
                 & ~(paddr == `APA_OFF_CTRL || paddr == `APA_OFF_OFFS
                     || paddr == `APA_OFF_MASK || paddr == `APA_OFF_ACK
                     || paddr == `APA_OFF_STAT);
  assign prdata = st_r.prdata;
  assign store_rd_idx = st_r.rd_idx;
  assign rx_highway_data = st_r.rx_data;
  assign rx_channel_parity = st_r.ch_par;
  assign rx_frame_pulse_n = st_r.fp_n;
  assign shared_status_out = st_r.shared;
  assign test_out_pos = st_r.test_pos;
  assign test_out_neg = st_r.test_neg;
  assign optical_nrz_out = st_r.opt;
  assign tx_multiframe_begin = st_r.mfb;
  assign datalink_start_flag = st_r.dl_flag;
endmodule

// file: logic/apa_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 25 MHz block clock, APB with byte addresses.
// Notes: Included by the pin output block only.
`ifndef APA_CFG_SVH
`define APA_CFG_SVH
`define APA_CLK_MHZ     25
`define APA_FP30_NS     488
`define APA_FP24_NS     648
`define APA_FP30_CYC    ((`APA_FP30_NS * `APA_CLK_MHZ) / 1000)
`define APA_FP24_CYC    ((`APA_FP24_NS * `APA_CLK_MHZ) / 1000)
`define APA_DF_LEAD     6'h04
`define APA_SIM_STEP_A  4'h2
`define APA_SIM_STEP_B  4'h6
`define APA_OFF_CTRL    12'h000
`define APA_OFF_OFFS    12'h004
`define APA_OFF_MASK    12'h008
`define APA_OFF_ACK     12'h00C
`define APA_OFF_STAT    12'h010
`define APA_CTRL_W      12
`define APA_CTRL_RST    12'h000
`define APA_OFFS_TRO_LSB 8
`define APA_ACK_ALARM   0
`define APA_ACK_MF      1
`define APA_ACK_DL      2
`define APA_SLOTS_2M    6'h1F
`define APA_SLOTS_4M    6'h3F
`define APA_IDLE_BYTE   8'hFF
`define APA_ESF_DL_FRM  7'h0C
`define APA_F72_STEP    7'h0C
`define APA_MF_LEN      2'h2
`endif

// file: logic/apa_pkg.sv
// Purpose: Types shared by the aligner pin output block.
// Assumes: Constants live in apa_cfg.svh.
// Notes: Control layout matches the control register, highest bit first.
package apa_pkg;
  typedef enum logic [2:0] {
    HW_IDLE = 3'b001,
    HW_OFFS = 3'b010,
    HW_RUN  = 3'b100
  } apa_hw_t;
  typedef struct packed {
    logic [1:0] mf_format;
    logic       code_sel;
    logic       optical_sense;
    logic       test_sense;
    logic       irq_select;
    logic       freeze_disable;
    logic       parity_type;
    logic       ctm;
    logic       sclk_rate;
    logic       hw_rate;
    logic       pcm24;
  } apa_ctrl_t;
  typedef struct packed {
    logic frame_start;
    logic superframe_start;
    logic framing_err;
    logic slip;
    logic sync_lost;
  } apa_rx_evt_t;
  typedef struct packed {
    logic       frame_start;
    logic [6:0] frame_num;
    logic       data_bit;
    logic       coded_pos;
    logic       coded_neg;
  } apa_tx_evt_t;
endpackage

// file: bench/apa_pin_out_props.sv
// Purpose: Port checker for the aligner pin output block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: Bound to the pin output module by the bind below.
`timescale 1ns/100ps
module apa_pin_out_chk (
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [11:0]          paddr,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 sys_clock,
  input wire apa_pkg::apa_rx_evt_t rx_evt,
  input wire apa_pkg::apa_tx_evt_t tx_evt,
  input wire logic                 rx_highway_data,
  input wire logic                 rx_frame_pulse_n,
  input wire logic                 tx_multiframe_begin,
  input wire logic                 datalink_start_flag
);
  import apa_pkg::*;
  logic       sc_q;
  logic [3:0] since_fall;
  logic [4:0] low_cnt;
  // Cycles since the system clock pin was seen falling.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sc_q       <= 1'h0;
      since_fall <= 4'hF;
      low_cnt    <= 5'h00;
    end else begin
      sc_q       <= sys_clock;
      since_fall <= (sc_q && !sys_clock) ? 4'h0 :
                    (since_fall == 4'hF) ? 4'hF : since_fall + 4'h1;
      low_cnt    <= rx_frame_pulse_n ? 5'h00 : low_cnt + 5'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_READY_HIGH: assert property (pready) // Zero wait bus
    else $error("pready low");
  AST_ERR_ONLY_ACCESS: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access");
  AST_ERR_UNMAPPED: assert property // Unmapped access
    (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no pslverr on unmapped");
  AST_HW_FALL_EDGE: assert property
    ($changed(rx_highway_data) |-> since_fall <= 4'h4)
    else $error("highway data moved off a falling edge");
  AST_FP_START: assert property
    (rx_evt.frame_start && !rx_evt.sync_lost ##1 !rx_evt.sync_lost
     |-> !rx_frame_pulse_n)
    else $error("frame pulse did not start");
  AST_FP_SUPPRESS: assert property
    (rx_evt.sync_lost && $past(rx_evt.sync_lost) |-> rx_frame_pulse_n)
    else $error("frame pulse during sync loss");
  AST_FP_WIDTH: assert property
    ($rose(rx_frame_pulse_n) && !$past(rx_evt.sync_lost)
     |-> low_cnt == 5'h0C || low_cnt == 5'h10)
    else $error("frame pulse width wrong");
  AST_MFB_CAUSE: assert property
    ($rose(tx_multiframe_begin) |-> $past(tx_evt.frame_start))
    else $error("multiframe begin without frame start");
  AST_DL_CAUSE: assert property
    ($rose(datalink_start_flag)
     |-> $past(tx_evt.frame_start) && $past(tx_evt.frame_num) == 7'h00)
    else $error("data link flag without frame zero");
endmodule
bind apa_pin_out apa_pin_out_chk chk_u (
  .clk, .rstn, .psel, .penable, .paddr, .pready, .pslverr, .sys_clock,
  .rx_evt, .tx_evt, .rx_highway_data, .rx_frame_pulse_n,
  .tx_multiframe_begin, .datalink_start_flag);

// file: bench/apa_hw_model.sv
// Purpose: System highway partner: clock, sync and highway capture.
// Assumes: Highway data is stable at each system clock fall.
// Notes: Captures five slots and the parity of slots 0 and 1.
`timescale 1ns/100ps
module apa_hw_model (
  input  wire logic       arm,
  input  wire logic [2:0] cpb,
  input  wire logic [7:0] off,
  input  wire logic       rx_highway_data,
  input  wire logic       rx_channel_parity,
  output logic            sys_clock,
  output logic            system_sync_pulse_n,
  output logic [39:0]     bits,
  output logic [1:0]      par,
  output logic            done
);
  int n;
  initial begin
    sys_clock = 1'h0;
    forever #122 sys_clock = ~sys_clock;
  end
  initial begin
    system_sync_pulse_n = 1'h1;
    bits = '0;
    par = '0;
    done = 1'h0;
    forever begin
      @(posedge arm);
      done = 1'h0;
      @(negedge sys_clock);
      system_sync_pulse_n <= 1'h0;
      @(negedge sys_clock);
      system_sync_pulse_n <= 1'h1;
      for (n = 1; n <= off + cpb * 40; n++) begin
        @(negedge sys_clock);
        if (n > off && (n - off - 1) % cpb == 0) begin
          bits = {bits[38:0], rx_highway_data};
          if ((n - off - 1) / cpb == 0 || (n - off - 1) / cpb == 8)
            par = {par[0], rx_channel_parity};
        end
      end
      done = 1'h1;
    end
  end
endmodule

// file: bench/testbench.sv
// Purpose: Self-checking bench for the aligner pin output block.
// Assumes: System clock 4096 kHz, route clock 320 ns period.
// Notes: Each scenario is its own task.
`timescale 1ns/100ps
module testbench;
  import apa_pkg::*;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        sys_clock, system_sync_pulse_n, tx_route_clock;
  apa_rx_evt_t rx_evt;
  apa_tx_evt_t tx_evt;
  logic [7:0]  alarm_src, store_rd_data, hw_off;
  logic [3:0]  alarm_sim_step;
  logic [4:0]  store_rd_idx;
  logic        rx_highway_data, rx_channel_parity, rx_frame_pulse_n;
  logic        shared_status_out, test_out_pos, test_out_neg;
  logic        optical_nrz_out, tx_multiframe_begin, datalink_start_flag;
  logic        hw_arm, hw_done;
  logic [2:0]  hw_cpb;
  logic [39:0] hw_bits;
  logic [1:0]  hw_par;
  int          n_errors, checks_done, cyc;
  assign store_rd_data = 8'hA5 ^ {3'h0, store_rd_idx};
  apa_pin_out dut_u (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sys_clock,
    .system_sync_pulse_n, .tx_route_clock, .rx_evt, .tx_evt, .alarm_src,
    .alarm_sim_step, .store_rd_idx, .store_rd_data, .rx_highway_data,
    .rx_channel_parity, .rx_frame_pulse_n, .shared_status_out,
    .test_out_pos, .test_out_neg, .optical_nrz_out, .tx_multiframe_begin,
    .datalink_start_flag);
  apa_hw_model hw_u (.arm(hw_arm), .cpb(hw_cpb), .off(hw_off),
    .rx_highway_data, .rx_channel_parity, .sys_clock,
    .system_sync_pulse_n, .bits(hw_bits), .par(hw_par), .done(hw_done));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    tx_route_clock = 1'h0;
    forever #160 tx_route_clock = ~tx_route_clock;
  end
  task automatic finish_test();
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic ctl(input apa_ctrl_t c);
    bus(1'h1, 12'h000, {20'h0_0000, c});
  endtask
  task automatic t_regs();
    chk({test_out_pos, test_out_neg, rx_frame_pulse_n}, 3'h7);
    bus(1'h0, 12'h000, 32'h0000_0000);
    chk({rerr, rdat}, 33'h0_0000_0000);
    bus(1'h1, 12'h000, 32'hFFFF_FFFF);
    bus(1'h0, 12'h000, 32'h0000_0000);
    chk({rerr, rdat}, 33'h0_0000_0FFF);
    bus(1'h1, 12'h024, 32'hFFFF_FFFF);
    chk(rerr, 1'h1);
    bus(1'h0, 12'h024, 32'h0000_0000);
    chk({rerr, rdat}, 33'h1_0000_0000);
    bus(1'h0, 12'h00C, 32'h0000_0000);
    chk({rerr, rdat}, 33'h0_0000_0000);
  endtask
  task automatic t_hw(input logic p24, hr, ct, pt,
                      input logic [5:0] tro, input logic [2:0] rco);
    apa_ctrl_t   c;
    logic [39:0] e;
    logic [7:0]  b;
    c = '0;
    c.pcm24 = p24;
    c.hw_rate = hr;
    c.ctm = ct;
    c.parity_type = pt;
    ctl(c);
    bus(1'h1, 12'h004, {18'h0_0000, tro, 5'h00, rco});
    hw_cpb <= hr ? 3'h1 : 3'h2;
    hw_off <= 8'(tro) * (hr ? 8'h08 : 8'h10) + 8'(rco);
    hw_arm <= 1'h1;
    @(posedge clk);
    hw_arm <= 1'h0;
    @(posedge clk);
    while (hw_done !== 1'h1) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      b = 8'hA5 ^ 8'(k);
      if (p24 && (k == 0 || (!ct && k == 4))) b = 8'hFF;
      else if (p24) b = 8'hA5 ^ 8'(k - 1);
      e = {e[31:0], b};
    end
    chk(hw_bits, e);
    if (!p24) chk(hw_par, {^8'hA5 ^ pt, ^8'hA4 ^ pt});
  endtask
  task automatic t_irq();
    apa_ctrl_t c;
    c = '0;
    c.irq_select = 1'h1;
    ctl(c);
    bus(1'h1, 12'h008, 32'h0000_0004);
    alarm_src <= 8'hFB;
    repeat (4) @(posedge clk);
    chk(shared_status_out, 1'h0);
    alarm_src <= 8'h04;
    @(posedge clk);
    alarm_src <= 8'h00;
    repeat (4) @(posedge clk);
    chk(shared_status_out, 1'h1);
    bus(1'h1, 12'h00C, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(shared_status_out, 1'h0);
  endtask
  task automatic sf();
    rx_evt.superframe_start <= 1'h1;
    @(posedge clk);
    rx_evt.superframe_start <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_frz();
    apa_ctrl_t c;
    c = '0;
    c.pcm24 = 1'h1;
    ctl(c);
    for (int i = 0; i < 3; i++) begin
      rx_evt <= apa_rx_evt_t'(5'h01 << i);
      @(posedge clk);
      rx_evt <= '0;
      repeat (3) @(posedge clk);
      chk(shared_status_out, 1'h1);
      sf();
      chk(shared_status_out, 1'h1);
      sf();
      chk(shared_status_out, 1'h0);
    end
    for (int s = 0; s < 8; s++) begin
      alarm_sim_step <= 4'(s);
      repeat (3) @(posedge clk);
      chk(shared_status_out, 40'(s == 2 || s == 6));
    end
    c.freeze_disable = 1'h1;
    ctl(c);
    alarm_sim_step <= 4'h2;
    repeat (3) @(posedge clk);
    chk(shared_status_out, 1'h0);
    alarm_sim_step <= 4'h0;
  endtask
  task automatic t_fp();
    apa_ctrl_t c;
    int        w;
    c = '0;
    for (int m = 0; m < 3; m++) begin
      c.pcm24 = (m == 1);
      ctl(c);
      alarm_sim_step <= (m == 1) ? 4'h2 : 4'h0;
      rx_evt.sync_lost <= (m == 2);
      @(posedge clk);
      rx_evt.frame_start <= 1'h1;
      @(posedge clk);
      rx_evt.frame_start <= 1'h0;
      w = 0;
      repeat (24) @(negedge clk) w += (rx_frame_pulse_n === 1'h0);
      chk(40'(w), (m == 0) ? 40'h0C : (m == 1) ? 40'h10 : 40'h0);
    end
    rx_evt.sync_lost <= 1'h0;
    alarm_sim_step <= 4'h0;
  endtask
  task automatic fs(input logic [6:0] num);
    tx_evt.frame_start <= 1'h1;
    tx_evt.frame_num   <= num;
    @(posedge clk);
    tx_evt.frame_start <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic t_mf();
    apa_ctrl_t c;
    c = '0;
    c.pcm24 = 1'h1;
    c.mf_format = 2'h2;
    ctl(c);
    fs(7'h05);
    chk(tx_multiframe_begin, 1'h0);
    fs(7'h0C);
    chk(tx_multiframe_begin, 1'h1);
    fs(7'h0D);
    chk(tx_multiframe_begin, 1'h1);
    fs(7'h0E);
    chk(tx_multiframe_begin, 1'h0);
    c.mf_format = 2'h3;
    ctl(c);
    fs(7'h00);
    chk({tx_multiframe_begin, datalink_start_flag}, 2'h3);
    bus(1'h1, 12'h00C, 32'h0000_0002);
    @(posedge clk);
    chk({tx_multiframe_begin, datalink_start_flag}, 2'h1);
    bus(1'h1, 12'h00C, 32'h0000_0004);
    fs(7'h0C);
    chk({tx_multiframe_begin, datalink_start_flag}, 2'h2);
  endtask
  task automatic t_tst();
    apa_ctrl_t c;
    c = '0;
    c.code_sel = 1'h1;
    tx_evt.coded_pos <= 1'h1;
    tx_evt.coded_neg <= 1'h0;
    tx_evt.data_bit  <= 1'h1;
    for (int s = 0; s < 2; s++) begin
      c.test_sense = s[0];
      c.optical_sense = s[0];
      ctl(c);
      repeat (24) @(posedge clk);
      chk({test_out_pos, test_out_neg, optical_nrz_out}, s ? 3'h4 : 3'h3);
    end
  endtask
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_evt, tx_evt, alarm_src, alarm_sim_step} = '0;
    {hw_arm, hw_cpb, hw_off, n_errors, checks_done, cyc} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    t_regs();
    t_hw(1'h0, 1'h0, 1'h0, 1'h0, 6'h00, 3'h0);
    t_hw(1'h0, 1'h1, 1'h0, 1'h1, 6'h00, 3'h2);
    t_hw(1'h0, 1'h0, 1'h0, 1'h0, 6'h01, 3'h3);
    t_hw(1'h1, 1'h0, 1'h1, 1'h0, 6'h00, 3'h0);
    t_hw(1'h1, 1'h0, 1'h0, 1'h0, 6'h00, 3'h0);
    t_irq();
    t_frz();
    t_fp();
    t_mf();
    t_tst();
    finish_test();
  end
endmodule
